/* File: rtl/fbio_pkg.sv */
// Function
// - Byte 11 code picks failsafe action: all low, all high, hold, per-channel.
// - Byte 12 bits 0..6 give substitute levels for channels 1..7.
// - Byte 12 bit 7 gives the substitute level for channel 8.
// - Byte 13 bits 0..7 give substitute levels for channels 9..16.
// - Records 0..3 exist; record 0 holds read-only order, serial, revisions.
// - Record 0 revision counter is two bytes and always reads zero.
// - Record 0 reports generic profile code and I/O module subtype.
// - Record 0 reports format version 1.2 and support mask for records 1..3.
// - Record 1 holds writable 32-byte function and 22-byte location tags, preset spaces.
// - Record 2 holds writable 16-byte date preset spaces, then 38 zero bytes.
// - Record 3 holds a writable 54-byte free text field preset spaces.
// - Sync copies received output data to outputs and holds until next sync.
// - Freeze captures inputs and reports the snapshot until next freeze.
// - Alarms enabled after reset; master may disable them by parameter.
// - Storing a diagnostic entry raises an incoming alarm.
// - Clearing a diagnostic entry raises an outgoing alarm.
// - System fault indicator lit while any diagnostic entry is stored.
// - Five diagnostic causes: overtemp, supply surge, supply overload, short, overload.
// - Watchdog starts on first output write; later writes restart it.
// - Master reads never restart the watchdog.
// - Watchdog expiry drives all outputs to the failsafe action picked by byte 11.
// - Watchdog expiry shows on the bus fault indicator.
// - Lost bus or no valid data forces outputs to the failsafe action picked by byte 11.
// - Output channels reflect their state in the input process data.
package fbio_pkg;
  localparam int         NCH          = 16;
  localparam logic [3:0] PRM_BEHAV    = 4'hB;
  localparam logic [3:0] PRM_SUBST_LO = 4'hC;
  localparam logic [3:0] PRM_SUBST_HI = 4'hD;
  localparam logic [3:0] PRM_MODES    = 4'hE;
  localparam int         MODE_SYNC    = 0;
  localparam int         MODE_FRZ     = 1;
  localparam int         MODE_ALMOFF  = 2;
  localparam int         MODE_WDEN    = 3;
  localparam logic [7:0] PRM_RST      = 8'h00;
  localparam logic [1:0] BEH_LOW      = 2'h0;
  localparam logic [1:0] BEH_HIGH     = 2'h1;
  localparam logic [1:0] BEH_HOLD     = 2'h2;
  localparam logic [1:0] BEH_SUBST    = 2'h3;
  localparam int         NDIAG        = 5;
  localparam int         DG_OVTEMP    = 0;
  localparam int         DG_SURGE     = 1;
  localparam int         DG_SUPOVL    = 2;
  localparam int         DG_SHORT     = 3;
  localparam int         DG_OUTOVL    = 4;
  localparam int         WD_DEF_CYC   = 250000;
  // Record layout: 64-byte slots, byte address = record*64 + byte index
  localparam int         REC_BYTES    = 64;
  localparam int         REC_AW       = 8;
  localparam int         R0_MAKER     = 0;
  localparam int         R0_ORDER     = 2;
  localparam int         R0_SERIAL    = 22;
  localparam int         R0_HWREV     = 38;
  localparam int         R0_FWREV     = 40;
  localparam int         R0_REVCNT    = 44;
  localparam int         R0_PROFILE   = 46;
  localparam int         R0_SUBTYPE   = 48;
  localparam int         R0_VERSION   = 50;
  localparam int         R0_SUPPORT   = 52;
  localparam int         R0_LEN       = 54;
  localparam int         R1_FUNC_LEN  = 32;
  localparam int         R1_LEN       = 54;
  localparam int         R2_DATE_LEN  = 16;
  localparam int         R2_LEN       = 54;
  localparam int         R3_LEN       = 54;
  localparam logic [7:0] CH_SPACE     = 8'h20;
  localparam logic [7:0] CH_ZERO      = 8'h00;
  localparam logic [15:0] REVCNT_VAL  = 16'h0000;
  localparam logic [15:0] PROFILE_VAL = 16'hF600;
  localparam logic [15:0] SUBTYPE_VAL = 16'h0003;
  localparam logic [15:0] VERSION_VAL = 16'h0102;
  localparam logic [15:0] SUPPORT_VAL = 16'h000E;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fbio_rec_req_s;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [NCH-1:0]   data;
  } fbio_pd_s;
endpackage

/* File: rtl/fbio_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// Writable record bytes with registered read data
module fbio_mem import fbio_pkg::*; #(
  parameter int DEPTH = 4 * REC_BYTES,
  parameter int AW    = REC_AW
) (
  input  wire logic          mclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* File: rtl/fbio_top.sv */
`timescale 1ns/1ns
`default_nettype none
module fbio_top import fbio_pkg::*; #(
  parameter int           WD_CYC     = WD_DEF_CYC,
  parameter logic [15:0]  MAKER_CODE = 16'h00A5, // Arbitrary value
  parameter logic [159:0] ORDER_CODE = {20{8'h30}},
  parameter logic [127:0] SERIAL_NO  = {16{8'h30}},
  parameter logic [15:0]  HW_REV     = 16'h0001,
  parameter logic [31:0]  FW_REV     = 32'h00000001
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  // Parameter byte writes from the bus stack
  input  wire logic            prm_wr,
  input  wire logic [3:0]      prm_addr,
  input  wire logic [7:0]      prm_wdata,
  // Cyclic process data and commands
  input  wire fbio_pd_s        pd_out,
  input  wire logic            sync_cmd,
  input  wire logic            freeze_cmd,
  input  wire logic            bus_lost,
  // Channel pins and channel-direction mask (1 = output)
  input  wire logic [NCH-1:0]  pin_in,
  input  wire logic [NCH-1:0]  ch_is_out,
  output logic      [NCH-1:0]  pin_out,
  output logic      [NCH-1:0]  pd_in,
  // Diagnostic causes (pin level)
  input  wire logic [NDIAG-1:0] diag_raw,
  output logic      [NDIAG-1:0] diag_stored,
  output logic                 alarm_in,
  output logic                 alarm_out,
  output logic                 system_fault_indicator,
  output logic                 bus_fault_indicator,
  // Identification records
  input  wire fbio_rec_req_s   rec_req,
  output logic                 rec_ack,
  output logic      [7:0]      rec_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter bytes
  logic [1:0]     behav_q, behav_d;
  logic [NCH-1:0] subst_q, subst_d;
  logic [7:0]     modes_q, modes_d;

  always_comb begin
    behav_d = behav_q;
    subst_d = subst_q;
    modes_d = modes_q;
    if (prm_wr) begin
      if (prm_addr == PRM_BEHAV) begin
        behav_d = prm_wdata[1:0];
      end else if (prm_addr == PRM_SUBST_LO) begin
        subst_d[7:0] = prm_wdata;
      end else if (prm_addr == PRM_SUBST_HI) begin
        subst_d[15:8] = prm_wdata;
      end else if (prm_addr == PRM_MODES) begin
        modes_d = prm_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      behav_q <= PRM_RST[1:0];
      subst_q <= {2{PRM_RST}};
      modes_q <= PRM_RST; // Alarm-off bit clear: alarms on after reset
    end else begin
      behav_q <= behav_d;
      subst_q <= subst_d;
      modes_q <= modes_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input and diagnostic synchronisers (3 stages, 2nd and 3rd agree)
  localparam int SW = NCH + NDIAG;
  logic [SW-1:0] s1_q, s2_q, s3_q, sv_q, sv_d;

  always_comb begin
    for (int i = 0; i < SW; i++) begin
      sv_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : sv_q[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sv_q <= '0;
    end else begin
      s1_q <= {diag_raw, pin_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      sv_q <= sv_d;
    end
  end

  logic [NCH-1:0]   pin_s;
  logic [NDIAG-1:0] diag_s;
  assign pin_s  = sv_q[NCH-1:0];
  assign diag_s = sv_q[SW-1:NCH];

  ////////////////////////////////////////////////////////////////////////////
  // Output path, sync, watchdog
  typedef enum logic [1:0] {FBIO_WD_IDLE, FBIO_WD_RUN, FBIO_WD_EXP} fbio_wd_e;
  fbio_wd_e       wd_q, wd_d;
  logic [31:0]    wdc_q, wdc_d;
  logic [NCH-1:0] rx_q, rx_d, held_q, held_d, out_q, out_d;
  logic           valid_q, valid_d;
  logic           failsafe;

  always_comb begin
    wd_d    = wd_q;
    wdc_d   = wdc_q;
    valid_d = valid_q;
    rx_d    = rx_q;
    held_d  = held_q;
    if (pd_out.wr) begin
      rx_d    = pd_out.data;
      valid_d = 1'b1;
    end
    if (bus_lost) begin
      valid_d = 1'b0;
    end
    // Sync freezes the outputs; otherwise they follow each write
    if (modes_q[MODE_SYNC]) begin
      if (sync_cmd) begin
        held_d = rx_d;
      end
    end else begin
      held_d = rx_d;
    end
    case (wd_q)
      FBIO_WD_IDLE: begin
        if (modes_q[MODE_WDEN] && pd_out.wr) begin
          wd_d  = FBIO_WD_RUN;
          wdc_d = '0;
        end
      end
      FBIO_WD_RUN: begin
        if (!modes_q[MODE_WDEN]) begin
          wd_d = FBIO_WD_IDLE;
        end else if (pd_out.wr) begin
          wdc_d = '0;
        end else if (wdc_q >= 32'(WD_CYC - 1)) begin
          wd_d = FBIO_WD_EXP;
        end else begin
          wdc_d = wdc_q + 32'h1;
        end
      end
      FBIO_WD_EXP: begin
        // Stays expired until fresh data arrives or the watchdog enable bit is cleared
        if (!modes_q[MODE_WDEN]) begin
          wd_d = FBIO_WD_IDLE;
        end else if (pd_out.wr) begin
          wd_d  = FBIO_WD_RUN;
          wdc_d = '0;
        end
      end
      default: wd_d = FBIO_WD_IDLE;
    endcase
  end

  assign failsafe = (wd_q == FBIO_WD_EXP) || !valid_q || bus_lost;

  always_comb begin
    out_d = held_q;
    if (failsafe) begin
      case (behav_q)
        BEH_LOW:   out_d = '0;
        BEH_HIGH:  out_d = '1;
        BEH_HOLD:  out_d = out_q;
        BEH_SUBST: out_d = subst_q;
        default:   out_d = '0;
      endcase
    end
    out_d = out_d & ch_is_out;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wd_q    <= FBIO_WD_IDLE;
      wdc_q   <= '0;
      valid_q <= 1'b0;
      rx_q    <= '0;
      held_q  <= '0;
      out_q   <= '0;
    end else begin
      wd_q    <= wd_d;
      wdc_q   <= wdc_d;
      valid_q <= valid_d;
      rx_q    <= rx_d;
      held_q  <= held_d;
      out_q   <= out_d;
    end
  end

  assign pin_out             = out_q;
  assign bus_fault_indicator = (wd_q == FBIO_WD_EXP);

  ////////////////////////////////////////////////////////////////////////////
  // Input path and freeze
  logic [NCH-1:0] live_in, pdin_q, pdin_d;

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      assign live_in[c] = ch_is_out[c] ? out_q[c] : pin_s[c];
    end
  endgenerate

  always_comb begin
    pdin_d = live_in;
    if (modes_q[MODE_FRZ]) begin
      pdin_d = freeze_cmd ? live_in : pdin_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pdin_q <= '0;
    end else begin
      pdin_q <= pdin_d;
    end
  end

  assign pd_in = pdin_q;

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostics and alarms
  logic [NDIAG-1:0] dg_q, dg_d;
  logic             ain_q, ain_d, aout_q, aout_d;

  always_comb begin
    dg_d   = diag_s;
    ain_d  = 1'b0;
    aout_d = 1'b0;
    if (!modes_q[MODE_ALMOFF]) begin
      ain_d  = |(dg_d & ~dg_q);
      aout_d = |(dg_q & ~dg_d);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dg_q   <= '0;
      ain_q  <= 1'b0;
      aout_q <= 1'b0;
    end else begin
      dg_q   <= dg_d;
      ain_q  <= ain_d;
      aout_q <= aout_d;
    end
  end

  assign diag_stored            = dg_q;
  assign alarm_in               = ain_q;
  assign alarm_out              = aout_q;
  assign system_fault_indicator = |dg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Identification records
  logic [1:0] rec_sel;
  logic [5:0] rec_idx;
  logic       rec_wr_ok;
  logic [7:0] rom_d, rom_q;
  logic       ack_q, ack_d;
  logic [1:0] rsel_q;
  logic       init_q, init_d;
  logic [REC_AW-1:0] ic_q, ic_d;
  logic [7:0] mem_rd, init_val, mwdata;
  logic [REC_AW-1:0] mwaddr;
  logic       mwe;

  assign rec_sel = rec_req.addr[7:6];
  assign rec_idx = rec_req.addr[5:0];

  // Record 0 is read-only; writable lengths bound records 1..3
  always_comb begin
    rec_wr_ok = 1'b0;
    if (rec_sel == 2'h1) begin
      rec_wr_ok = (int'(rec_idx) < R1_LEN);
    end else if (rec_sel == 2'h2) begin
      rec_wr_ok = (int'(rec_idx) < R2_LEN);
    end else if (rec_sel == 2'h3) begin
      rec_wr_ok = (int'(rec_idx) < R3_LEN);
    end
  end

  // Preset values by byte address, loaded once after reset
  always_comb begin
    init_val = CH_ZERO;
    if (ic_q[7:6] == 2'h1) begin
      init_val = (int'(ic_q[5:0]) < R1_LEN) ? CH_SPACE : CH_ZERO;
    end else if (ic_q[7:6] == 2'h2) begin
      init_val = (int'(ic_q[5:0]) < R2_DATE_LEN) ? CH_SPACE : CH_ZERO;
    end else if (ic_q[7:6] == 2'h3) begin
      init_val = (int'(ic_q[5:0]) < R3_LEN) ? CH_SPACE : CH_ZERO;
    end
  end

  always_comb begin
    init_d = init_q;
    ic_d   = ic_q;
    if (init_q) begin
      ic_d = ic_q + REC_AW'(1);
      if (ic_q == '1) begin
        init_d = 1'b0;
      end
    end
  end

  assign mwe    = init_q || (rec_req.wr && rec_wr_ok);
  assign mwaddr = init_q ? ic_q : rec_req.addr;
  assign mwdata = init_q ? init_val : rec_req.wdata;

  fbio_mem u_mem (
    .mclk  (mclk),
    .we    (mwe),
    .waddr (mwaddr),
    .wdata (mwdata),
    .raddr (rec_req.addr),
    .rdata (mem_rd)
  );

  // Record 0 fields, big-endian bytes
  always_comb begin
    int i;
    i     = int'(rec_idx);
    rom_d = CH_ZERO;
    if (i < R0_ORDER) begin
      rom_d = MAKER_CODE[8*(R0_ORDER-1-i) +: 8];
    end else if (i < R0_SERIAL) begin
      rom_d = ORDER_CODE[8*(R0_SERIAL-1-i) +: 8];
    end else if (i < R0_HWREV) begin
      rom_d = SERIAL_NO[8*(R0_HWREV-1-i) +: 8];
    end else if (i < R0_FWREV) begin
      rom_d = HW_REV[8*(R0_FWREV-1-i) +: 8];
    end else if (i < R0_REVCNT) begin
      rom_d = FW_REV[8*(R0_REVCNT-1-i) +: 8];
    end else if (i < R0_PROFILE) begin
      rom_d = REVCNT_VAL[8*(R0_PROFILE-1-i) +: 8];
    end else if (i < R0_SUBTYPE) begin
      rom_d = PROFILE_VAL[8*(R0_SUBTYPE-1-i) +: 8];
    end else if (i < R0_VERSION) begin
      rom_d = SUBTYPE_VAL[8*(R0_VERSION-1-i) +: 8];
    end else if (i < R0_SUPPORT) begin
      rom_d = VERSION_VAL[8*(R0_SUPPORT-1-i) +: 8];
    end else if (i < R0_LEN) begin
      rom_d = SUPPORT_VAL[8*(R0_LEN-1-i) +: 8];
    end
  end

  assign ack_d = (rec_req.rd || rec_req.wr) && !init_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rsel_q <= '0;
      rom_q  <= '0;
      init_q <= 1'b1;
      ic_q   <= '0;
    end else begin
      ack_q  <= ack_d;
      rsel_q <= rec_sel;
      rom_q  <= rom_d;
      init_q <= init_d;
      ic_q   <= ic_d;
    end
  end

  assign rec_ack   = ack_q;
  assign rec_rdata = (rsel_q == 2'h0) ? rom_q : mem_rd;
endmodule
`default_nettype wire

/* File: sim/fbio_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module fbio_top_sva import fbio_pkg::*; #(
  parameter int WD_CYC = 20
) (
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic             prm_wr,
  input wire logic [3:0]       prm_addr,
  input wire logic [7:0]       prm_wdata,
  input wire fbio_pd_s         pd_out,
  input wire logic             sync_cmd,
  input wire logic             freeze_cmd,
  input wire logic [NCH-1:0]   pin_out,
  input wire logic [NCH-1:0]   pd_in,
  input wire logic [NDIAG-1:0] diag_stored,
  input wire logic             alarm_in,
  input wire logic             alarm_out,
  input wire logic             system_fault_indicator,
  input wire logic             bus_fault_indicator,
  input wire fbio_rec_req_s    rec_req,
  input wire logic             rec_ack
);
  logic [3:0] mode_q, mode_d;
  logic [9:0] idle_q, idle_d;
  logic [8:0] age_q, age_d;
  logic       arm_q, arm_d;
  logic       wd_on;

  always_comb begin
    mode_d = (prm_wr && prm_addr == PRM_MODES) ? prm_wdata[3:0] : mode_q;
    idle_d = pd_out.wr ? 10'h000 : idle_q + 10'(idle_q != 10'h3FF);
    age_d  = age_q + 9'(age_q != 9'h12C);
    // Disarm with the enable so a later re-enable waits for a fresh write
    arm_d  = mode_q[MODE_WDEN] & (arm_q | pd_out.wr);
  end
  // Counters saturate so long idle spans never wrap into a false window
  always_ff @(posedge mclk) begin
    mode_q <= rst ? 4'h0 : mode_d;
    idle_q <= rst ? 10'h000 : idle_d;
    age_q  <= rst ? 9'h000 : age_d;
    arm_q  <= rst ? 1'b0 : arm_d;
  end
  assign wd_on = arm_q & mode_q[MODE_WDEN];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  a_fault_lit: assert property (|diag_stored |-> ##[0:1] system_fault_indicator)
    else $error("fault indicator dark");
  a_fault_dark: assert property ((diag_stored == '0) [*2] |-> !system_fault_indicator)
    else $error("fault indicator lit");
  // Alarm pulses are registered on the same edge as the stored entries
  a_alarm_in_new: assert property
    (|(diag_stored & ~$past(diag_stored)) && !$past(mode_q[MODE_ALMOFF]) |-> alarm_in)
    else $error("incoming alarm missing");
  a_alarm_out_gone: assert property
    (|(~diag_stored & $past(diag_stored)) && !$past(mode_q[MODE_ALMOFF]) |-> alarm_out)
    else $error("outgoing alarm missing");
  a_alarm_quiet: assert property (mode_q[MODE_ALMOFF] [*2] |-> !alarm_in && !alarm_out)
    else $error("alarm while disabled");
  a_rec_ack_time: assert property ((rec_req.rd || rec_req.wr) && age_q == 9'h12C |=> rec_ack)
    else $error("record ack late");
  a_rec_ack_cause: assert property (rec_ack |-> $past(rec_req.rd || rec_req.wr))
    else $error("record ack without request");
  a_wd_expiry: assert property (wd_on && idle_q == 10'(WD_CYC + 3) |-> bus_fault_indicator)
    else $error("watchdog did not expire");
  a_wd_early: assert property
    (wd_on && idle_q > 10'h003 && idle_q < 10'(WD_CYC - 1) |-> !bus_fault_indicator)
    else $error("watchdog expired early");
  a_sync_hold: assert property
    ((mode_q[MODE_SYNC] && !sync_cmd && !prm_wr && !bus_fault_indicator) [*3] |-> $stable(pin_out))
    else $error("outputs moved without sync");
  a_freeze_hold: assert property ((mode_q[MODE_FRZ] && !freeze_cmd) [*3] |-> $stable(pd_in))
    else $error("inputs moved without freeze");

  c_alarm: cover property (alarm_in);
  c_expire: cover property ($rose(bus_fault_indicator));
  c_freeze: cover property (mode_q[MODE_FRZ] && freeze_cmd);
endmodule

bind fbio_top fbio_top_sva #(.WD_CYC(WD_CYC)) u_fbio_top_sva (.*);
`default_nettype wire

/* File: sim/fbio_mst.sv */
`timescale 1ns/1ns
`default_nettype none
// Bus master model: each request rises after a falling edge and lasts one cycle
module fbio_mst import fbio_pkg::*; (
  input  wire logic         mclk,
  output var logic          prm_wr,
  output var logic [3:0]    prm_addr,
  output var logic [7:0]    prm_wdata,
  output var fbio_pd_s      pd_out,
  output var logic          sync_cmd,
  output var logic          freeze_cmd,
  output var fbio_rec_req_s rec_req
);
  initial begin
    prm_wr = 1'b0;
    prm_addr = 4'h0;
    prm_wdata = 8'h00;
    pd_out = '0;
    sync_cmd = 1'b0;
    freeze_cmd = 1'b0;
    rec_req = '0;
  end
  task automatic put_prm(input logic [3:0] a, input logic [7:0] dv);
    @(negedge mclk);
    prm_addr = a;
    prm_wdata = dv;
    prm_wr = 1'b1;
    @(negedge mclk);
    prm_wr = 1'b0;
    prm_wdata = ~dv; // Stale data flips so a missed strobe check cannot pass by luck
  endtask
  task automatic put_pd(input logic w, input logic r, input logic [NCH-1:0] dv);
    @(negedge mclk);
    pd_out = '{wr: w, rd: r, data: dv};
    @(negedge mclk);
    pd_out = '{wr: 1'b0, rd: 1'b0, data: ~dv};
  endtask
  // Callers enable the matching mode byte bit before sending these
  task automatic pulse(input logic is_sync);
    @(negedge mclk);
    sync_cmd = is_sync;
    freeze_cmd = ~is_sync;
    @(negedge mclk);
    sync_cmd = 1'b0;
    freeze_cmd = 1'b0;
  endtask
  task automatic rec_op(input logic w, input logic [7:0] a, input logic [7:0] dv);
    @(negedge mclk);
    rec_req = '{wr: w, rd: ~w, addr: a, wdata: dv};
    @(negedge mclk);
    rec_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~dv};
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench import fbio_pkg::*; ;
  localparam logic [15:0] MAKER = 16'h005A; // Arbitrary value
  localparam logic [79:0] R0_TAIL = 80'h0000_F600_0003_0102_000E;
  logic               mclk, rst, bus_lost, prm_wr, sync_cmd, freeze_cmd;
  logic               alarm_in, alarm_out, rec_ack;
  logic               system_fault_indicator, bus_fault_indicator;
  logic [NCH-1:0]     pin_in, ch_is_out, pin_out, pd_in, d, s;
  logic [NDIAG-1:0]   diag_raw, diag_stored;
  logic [3:0]         prm_addr;
  logic [7:0]         prm_wdata, rec_rdata, v;
  logic [8:0]         e;
  logic [8:0]         expq[$];
  fbio_pd_s           pd_out;
  fbio_rec_req_s      rec_req;
  int                 n_errors, num_checks, n_alm, n_alo;

  fbio_mst u_fbio_mst (.*);
  fbio_top #(.WD_CYC(20), .MAKER_CODE(MAKER)) u_fbio_top (.*);

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic rec(input logic w, input int a, input logic [7:0] dv, input logic [7:0] ex);
    expq.push_back({~w, ex});
    u_fbio_mst.rec_op(w, 8'(a), dv);
  endtask
  function automatic logic [15:0] fsv(input int b, input logic [15:0] dv, input logic [15:0] sv);
    case (b)
      0: return 16'h0000;
      1: return 16'hFFFF;
      2: return dv;
      default: return sv;
    endcase
  endfunction
  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Reads carry a flag; write acks only drain the queue
  always @(negedge mclk) begin
    if (alarm_in === 1'b1) n_alm++;
    if (alarm_out === 1'b1) n_alo++;
    if (rec_ack === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 9'h1FF;
      if (e[8]) chk("rec_rdata", {8'h00, e[7:0]}, {8'h00, rec_rdata});
    end
  end

  initial begin
    wt(5000);
    n_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(8330));
    rst = 1'b1;
    bus_lost = 1'b0;
    pin_in = 16'h0000;
    ch_is_out = 16'hFFFF;
    diag_raw = 5'h00;
    wt(12);
    rst = 1'b0;
    u_fbio_mst.put_prm(PRM_BEHAV, 8'h01);
    wt(2);
    chk("pin_out", 16'hFFFF, pin_out);
    for (int b = 0; b < 4; b++) begin
      d = 16'($urandom);
      s = 16'($urandom);
      u_fbio_mst.put_prm(PRM_SUBST_LO, s[7:0]);
      u_fbio_mst.put_prm(PRM_SUBST_HI, s[15:8]);
      u_fbio_mst.put_pd(1'b1, 1'b0, d);
      u_fbio_mst.put_prm(PRM_BEHAV, 8'(b));
      wt(1);
      chk("pin_out", d, pin_out);
      bus_lost = 1'b1;
      wt(3);
      chk("pin_out", fsv(b, d, s), pin_out);
      bus_lost = 1'b0;
      wt(3);
      chk("pin_out", fsv(b, d, s), pin_out);
    end
    u_fbio_mst.put_prm(PRM_MODES, 8'h08);
    for (int i = 0; i < 3; i++) begin
      d = 16'($urandom);
      u_fbio_mst.put_pd(1'b1, 1'b0, d);
      wt(12);
    end
    chk("bus_fault", 16'h0000, 16'(bus_fault_indicator));
    repeat (6) u_fbio_mst.put_pd(1'b0, 1'b1, ~d);
    wt(2);
    chk("bus_fault", 16'h0001, 16'(bus_fault_indicator));
    chk("pin_out", s, pin_out);
    u_fbio_mst.put_pd(1'b1, 1'b0, d);
    wt(2);
    chk("bus_fault", 16'h0000, 16'(bus_fault_indicator));
    chk("pin_out", d, pin_out);
    u_fbio_mst.put_prm(PRM_MODES, 8'h01);
    s = d;
    d = 16'($urandom);
    u_fbio_mst.put_pd(1'b1, 1'b0, d);
    wt(3);
    chk("pin_out", s, pin_out);
    u_fbio_mst.pulse(1'b1);
    wt(2);
    chk("pin_out", d, pin_out);
    u_fbio_mst.put_pd(1'b1, 1'b0, ~d);
    wt(3);
    chk("pin_out", d, pin_out);
    u_fbio_mst.put_prm(PRM_MODES, 8'h00);
    ch_is_out = 16'hFF00;
    pin_in = 16'($urandom);
    u_fbio_mst.put_pd(1'b1, 1'b0, d);
    wt(8);
    s = (d & ch_is_out) | (pin_in & ~ch_is_out);
    chk("pd_in", s, pd_in);
    u_fbio_mst.put_prm(PRM_MODES, 8'h02);
    u_fbio_mst.pulse(1'b0);
    pin_in = ~pin_in;
    wt(8);
    chk("pd_in", s, pd_in);
    u_fbio_mst.pulse(1'b0);
    wt(2);
    chk("pd_in", (d & ch_is_out) | (pin_in & ~ch_is_out), pd_in);
    u_fbio_mst.put_prm(PRM_MODES, 8'h00);
    for (int i = 0; i < NDIAG; i++) begin
      diag_raw = 5'(1 << i);
      wt(6);
      chk("diag_stored", 16'(diag_raw), 16'(diag_stored));
      chk("sys_fault", 16'h0001, 16'(system_fault_indicator));
      diag_raw = 5'h00;
      wt(6);
      chk("sys_fault", 16'h0000, 16'(system_fault_indicator));
    end
    chk("alarm count", 16'h0005, 16'(n_alm));
    chk("alarm_out count", 16'h0005, 16'(n_alo));
    u_fbio_mst.put_prm(PRM_MODES, 8'h04);
    diag_raw = 5'h1F;
    wt(6);
    diag_raw = 5'h00;
    wt(100);
    chk("alarm count", 16'h0005, 16'(n_alm));
    chk("alarm_out count", 16'h0005, 16'(n_alo));
    rec(1'b0, 0, 8'h00, MAKER[15:8]);
    for (int i = 0; i < 10; i++) rec(1'b0, 44 + i, 8'h00, R0_TAIL[79 - 8 * i -: 8]);
    rec(1'b1, 46, 8'h55, 8'h00);
    rec(1'b0, 46, 8'h00, 8'hF6);
    rec(1'b0, 64, 8'h00, CH_SPACE);
    rec(1'b0, 64 + R1_FUNC_LEN, 8'h00, CH_SPACE);
    rec(1'b0, 128 + R2_DATE_LEN - 1, 8'h00, CH_SPACE);
    rec(1'b0, 128 + R2_DATE_LEN, 8'h00, CH_ZERO);
    rec(1'b0, 192 + R3_LEN - 1, 8'h00, CH_SPACE);
    v = 8'($urandom);
    rec(1'b1, 64 + 53, v, 8'h00);
    rec(1'b0, 64 + 53, 8'h00, v);
    rec(1'b1, 192, ~v, 8'h00);
    rec(1'b0, 192, 8'h00, ~v);
    wt(3);
    chk("pending acks", 16'h0000, 16'(expq.size()));
    report_and_stop();
  end
endmodule
`default_nettype wire
